// >>> src/ccop_pkg.sv
// capacitor charge optimizer: register map, reset values, states, config
// assumes 4-bit capacitor setting codes shared with the power stage
package ccop_pkg;

  // register byte addresses
  localparam logic [7:0] PROF_SEL_ADDR = 8'h07;
  localparam logic [7:0] PROF_CTRL_ADDR = 8'h08;
  localparam logic [7:0] CAP_LIMIT_ADDR = 8'h12;
  localparam logic [7:0] MARGIN_ADDR = 8'h13;

  // field positions
  localparam int START_BIT = 0;
  localparam int PROF_CLR_BIT = 3;
  localparam int CEIL_SEL_BIT = 4;

  // values after reset
  localparam logic [5:0] PROF_RESET = 6'h01;
  localparam logic [1:0] MARGIN_RESET = 2'h3;
  localparam logic [3:0] VFIX_RESET = 4'h8;
  localparam logic CEIL_SEL_RESET = 1'b1;

  // capacitor setting codes and steps
  localparam logic [3:0] CEIL_HI = 4'hf;
  localparam logic [3:0] CEIL_LO = 4'he;
  localparam logic [3:0] LEVEL_MIN = 4'h0;
  localparam logic [4:0] STEP_ONE = 5'h01;
  localparam logic [4:0] STEP_TWO = 5'h02;

  // profile storage
  localparam int NUM_PROF = 64;
  localparam logic [5:0] LAST_PROF = 6'h3f;
  localparam logic [5:0] FIRST_PROF = 6'h00;
  localparam logic [5:0] FIXED_PROF = 6'h00;

  typedef enum logic [2:0] {
    ST_INIT = 3'b000,
    ST_IDLE = 3'b001,
    ST_CHARGE = 3'b010,
    ST_ACTIVE = 3'b011,
    ST_UPDATE = 3'b100
  } ccop_state_t;

  typedef struct packed {
    logic [5:0] prof;
    logic [3:0] vfix;
    logic ceil_sel;
    logic [1:0] margin;
  } ccop_cfg_t;

endpackage

// >>> src/ccop_sync2.sv
// two-stage synchroniser for one level from outside the clock domain
// assumes the enable freezes both stages together
`timescale 1ns/1ns
`default_nettype none
module ccop_sync2 (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic ce_in,
  input wire logic d_in,
  output logic q_out
);
  logic meta_r;

  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
    begin
      meta_r <= 1'b0;
      q_out <= 1'b0;
    end
    else if (ce_in)
    begin
      meta_r <= d_in;
      q_out <= meta_r;
    end
  end
endmodule // ccop_sync2
`default_nettype wire

// >>> src/ccop_top.sv
// capacitor charge optimizer: per-profile learned charge target and cycle
// assumes power stage reports charge/active done and quantised cap voltage
//
// Overview of operation
// [R1] each profile keeps a learned charge target following its load demand
// [R2] learned targets live in a private store used for nothing else
// [R3] profile zero uses fixed target; other profiles adapt automatically
// [R4] starting optimisation loads the profile target with the ceiling
// [R5] start by register write or start pin charges to the target
// [R6] when charging finishes an active cycle supplies the load
// [R7] at active end capacitor voltage is compared to margin threshold
// [R8] above threshold lowers the learned target by exactly one step
// [R9] below threshold raises the learned target by one or more steps
// [R10] initialisation sweep runs after every power-on reset
// [R11] writing one to profile reset restarts that profile's learning
// [R12] profile one is selected after reset
// [R13] profile zero disables optimiser, charges to fixed level
// [R14] up to sixty-four profiles, each with its own store entry
// [R15] after reset profile one and most conservative margin are enabled
// [R16] voltage equal to threshold counts as below, raise by one
`timescale 1ns/1ns
`default_nettype none
module ccop_top (
  input wire logic CLK_IN,
  input wire logic RESET_N_IN,
  input wire logic CE_IN,
  input wire logic REG_WR_IN,
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic [7:0] REG_WDATA_IN,
  output logic [7:0] REG_RDATA_OUT,
  input wire logic START_PIN_IN,
  input wire logic CHARGE_DONE_IN,
  input wire logic ACTIVE_DONE_IN,
  input wire logic [3:0] STORAGE_CAPACITOR_VOLTAGE_IN,
  output logic CHARGE_EN_OUT,
  output logic ACTIVE_EN_OUT,
  output logic [3:0] CHARGE_TARGET_OUT
);
  ccop_pkg::ccop_cfg_t cfg_r;
  ccop_pkg::ccop_state_t state_r;
  logic [3:0] level_mem [ccop_pkg::NUM_PROF];
  logic [5:0] idx_r;
  logic [5:0] act_prof_r;
  logic [3:0] storage_capacitor_voltage_r;
  logic pin_sync;
  logic pin_last_r;
  logic wr_ctrl;
  logic start_req;
  logic rst_hit;
  logic [3:0] ceiling;
  logic [3:0] cur_level;
  logic [3:0] level_nxt;
  logic [4:0] raised;

  ccop_sync2 u_start_sync (
    .clk_in(CLK_IN),
    .reset_n_in(RESET_N_IN),
    .ce_in(CE_IN),
    .d_in(START_PIN_IN),
    .q_out(pin_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // register writes and start requests

  assign wr_ctrl = REG_WR_IN && (REG_ADDR_IN == ccop_pkg::PROF_CTRL_ADDR);
  assign start_req = (wr_ctrl && REG_WDATA_IN[ccop_pkg::START_BIT])
    || (pin_sync && !pin_last_r); // R5
  assign rst_hit = wr_ctrl && REG_WDATA_IN[ccop_pkg::PROF_CLR_BIT];
  assign ceiling = cfg_r.ceil_sel ? ccop_pkg::CEIL_HI : ccop_pkg::CEIL_LO;
  assign cur_level = level_mem[act_prof_r];

  always_ff @(posedge CLK_IN)
  begin
    if (!RESET_N_IN)
    begin
      cfg_r.prof <= ccop_pkg::PROF_RESET; // R12
      cfg_r.vfix <= ccop_pkg::VFIX_RESET;
      cfg_r.ceil_sel <= ccop_pkg::CEIL_SEL_RESET;
      cfg_r.margin <= ccop_pkg::MARGIN_RESET; // R15
    end
    else if (CE_IN && REG_WR_IN)
    begin
      case (REG_ADDR_IN)
        ccop_pkg::PROF_SEL_ADDR: cfg_r.prof <= REG_WDATA_IN[5:0];
        ccop_pkg::CAP_LIMIT_ADDR:
        begin
          cfg_r.vfix <= REG_WDATA_IN[3:0];
          cfg_r.ceil_sel <= REG_WDATA_IN[ccop_pkg::CEIL_SEL_BIT];
        end
        ccop_pkg::MARGIN_ADDR: cfg_r.margin <= REG_WDATA_IN[1:0];
        default: cfg_r <= cfg_r;
      endcase
    end
  end

  always_ff @(posedge CLK_IN)
  begin
    if (!RESET_N_IN)
      pin_last_r <= 1'b0;
    else if (CE_IN)
      pin_last_r <= pin_sync;
  end

  always_ff @(posedge CLK_IN)
  begin
    if (!RESET_N_IN)
      REG_RDATA_OUT <= 8'h00;
    else if (CE_IN)
    begin
      case (REG_ADDR_IN)
        ccop_pkg::PROF_SEL_ADDR: REG_RDATA_OUT <= {2'h0, cfg_r.prof};
        ccop_pkg::PROF_CTRL_ADDR:
          REG_RDATA_OUT <= {level_mem[cfg_r.prof], 1'b0, state_r};
        ccop_pkg::CAP_LIMIT_ADDR:
          REG_RDATA_OUT <= {3'h0, cfg_r.ceil_sel, cfg_r.vfix};
        ccop_pkg::MARGIN_ADDR: REG_RDATA_OUT <= {6'h00, cfg_r.margin};
        default: REG_RDATA_OUT <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // cycle sequencer

  always_ff @(posedge CLK_IN)
  begin
    if (!RESET_N_IN)
    begin
      state_r <= ccop_pkg::ST_INIT; // R10
      idx_r <= ccop_pkg::FIRST_PROF;
      act_prof_r <= ccop_pkg::FIXED_PROF;
      storage_capacitor_voltage_r <= ccop_pkg::LEVEL_MIN;
      CHARGE_EN_OUT <= 1'b0;
      ACTIVE_EN_OUT <= 1'b0;
      CHARGE_TARGET_OUT <= ccop_pkg::LEVEL_MIN;
    end
    else if (CE_IN)
    begin
      case (state_r)
        ccop_pkg::ST_INIT:
        begin
          idx_r <= idx_r + 6'h01;
          if (idx_r == ccop_pkg::LAST_PROF)
            state_r <= ccop_pkg::ST_IDLE;
        end
        ccop_pkg::ST_IDLE:
          if (start_req)
          begin
            act_prof_r <= cfg_r.prof;
            CHARGE_EN_OUT <= 1'b1;
            if (cfg_r.prof == ccop_pkg::FIXED_PROF)
              CHARGE_TARGET_OUT <= cfg_r.vfix; // R13 R3
            else
              CHARGE_TARGET_OUT <= level_mem[cfg_r.prof]; // R1 R5
            state_r <= ccop_pkg::ST_CHARGE;
          end
        ccop_pkg::ST_CHARGE:
          if (CHARGE_DONE_IN)
          begin
            CHARGE_EN_OUT <= 1'b0;
            ACTIVE_EN_OUT <= 1'b1; // R6
            state_r <= ccop_pkg::ST_ACTIVE;
          end
        ccop_pkg::ST_ACTIVE:
          if (ACTIVE_DONE_IN)
          begin
            ACTIVE_EN_OUT <= 1'b0;
            storage_capacitor_voltage_r <= STORAGE_CAPACITOR_VOLTAGE_IN; // R7
            state_r <= ccop_pkg::ST_UPDATE;
          end
        ccop_pkg::ST_UPDATE: state_r <= ccop_pkg::ST_IDLE;
        default: state_r <= ccop_pkg::ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // learned level store and adaptation

  always_comb
  begin
    raised = 5'h00;
    if (storage_capacitor_voltage_r > {2'h0, cfg_r.margin}) // R7
    begin
      if (cur_level == ccop_pkg::LEVEL_MIN)
        level_nxt = ccop_pkg::LEVEL_MIN;
      else
        level_nxt = cur_level - 4'h1; // R8
    end
    else
    begin
      // one step near the threshold, two when well below it
      if (storage_capacitor_voltage_r + 4'h1 >= {2'h0, cfg_r.margin}) // R16
        raised = {1'b0, cur_level} + ccop_pkg::STEP_ONE;
      else
        raised = {1'b0, cur_level} + ccop_pkg::STEP_TWO; // R9
      level_nxt = (raised > {1'b0, ceiling}) ? ceiling : raised[3:0];
    end
  end

  always_ff @(posedge CLK_IN)
  begin
    if (CE_IN)
    begin
      if (state_r == ccop_pkg::ST_INIT)
        level_mem[idx_r] <= ceiling; // R4 R10 R14
      else if (rst_hit)
        level_mem[cfg_r.prof] <= ceiling; // R11 R4
      else if (state_r == ccop_pkg::ST_UPDATE
               && act_prof_r != ccop_pkg::FIXED_PROF)
        level_mem[act_prof_r] <= level_nxt; // R2 R3
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking @(posedge CLK_IN);
  endclocking
  default disable iff (!RESET_N_IN);

  sequence cycle_start_s;
    CE_IN && state_r == ccop_pkg::ST_IDLE && start_req;
  endsequence

  sequence learn_update_s;
    CE_IN && state_r == ccop_pkg::ST_UPDATE && !rst_hit
      && act_prof_r != ccop_pkg::FIXED_PROF;
  endsequence

  learned_target_a: assert property ( // R1
    cycle_start_s and (cfg_r.prof != ccop_pkg::FIXED_PROF) |=>
      CHARGE_EN_OUT && CHARGE_TARGET_OUT == $past(level_mem[cfg_r.prof]))
    else $error("charge target not the learned level");

  fixed_target_a: assert property ( // R13
    cycle_start_s and (cfg_r.prof == ccop_pkg::FIXED_PROF) |=>
      CHARGE_TARGET_OUT == $past(cfg_r.vfix))
    else $error("fixed mode target wrong");

  charge_to_active_a: assert property ( // R6
    CE_IN && state_r == ccop_pkg::ST_CHARGE && CHARGE_DONE_IN |=>
      ACTIVE_EN_OUT && !CHARGE_EN_OUT ##0 state_r == ccop_pkg::ST_ACTIVE)
    else $error("active cycle did not follow charge");

  lower_step_a: assert property ( // R8
    learn_update_s and (storage_capacitor_voltage_r > {2'h0, cfg_r.margin})
      and (cur_level != ccop_pkg::LEVEL_MIN) |=>
      level_mem[$past(act_prof_r)] == $past(cur_level) - 4'h1)
    else $error("learned level not lowered by one");

  raise_step_a: assert property ( // R9
    learn_update_s and (storage_capacitor_voltage_r < {2'h0, cfg_r.margin})
      and (cur_level < ceiling) |=>
      level_mem[$past(act_prof_r)] > $past(cur_level))
    else $error("learned level not raised");

  equal_raise_a: assert property ( // R16
    learn_update_s and (storage_capacitor_voltage_r == {2'h0, cfg_r.margin})
      and (cur_level < ceiling) |=>
      level_mem[$past(act_prof_r)] == $past(cur_level) + 4'h1)
    else $error("equal voltage did not raise by one");

  init_fill_a: assert property ( // R10
    CE_IN && state_r == ccop_pkg::ST_INIT |=>
      level_mem[$past(idx_r)] == $past(ceiling))
    else $error("init sweep did not load ceiling");

  init_end_a: assert property ( // R14
    CE_IN && state_r == ccop_pkg::ST_INIT && idx_r == ccop_pkg::LAST_PROF
      |=> state_r == ccop_pkg::ST_IDLE)
    else $error("init sweep did not end after last profile");

  profile_reset_a: assert property ( // R11
    CE_IN && rst_hit && state_r != ccop_pkg::ST_INIT |=>
      level_mem[$past(cfg_r.prof)] == $past(ceiling))
    else $error("profile reset did not reload ceiling");

  reset_defaults_a: assert property ( // R15
    @(posedge CLK_IN) disable iff (1'b0)
    !RESET_N_IN |=> cfg_r.prof == ccop_pkg::PROF_RESET
      && cfg_r.margin == ccop_pkg::MARGIN_RESET
      && state_r == ccop_pkg::ST_INIT)
    else $error("reset defaults wrong");

endmodule // ccop_top
`default_nettype wire

// >>> verif/ccop_pwr_model.sv
// power stage model: answers charge and active phases of the optimizer
// assumes the bench sets end-of-active voltage code and reply delay
`timescale 1ns/1ns
`default_nettype none
module ccop_pwr_model (
  input wire logic clk_in,
  input wire logic charge_en_in,
  input wire logic active_en_in,
  input wire logic [3:0] end_voltage_in,
  input wire logic [3:0] wait_in,
  output logic charge_done_out,
  output logic active_done_out,
  output logic [3:0] voltage_out
);
  int cnt;
  initial
  begin
    charge_done_out = 1'b0;
    active_done_out = 1'b0;
    voltage_out = 4'h0;
    cnt = 0;
  end
  // voltage code only meaningful with active done; otherwise it toggles
  always @(negedge clk_in)
  begin
    charge_done_out <= 1'b0;
    active_done_out <= 1'b0;
    voltage_out <= ~voltage_out;
    if ((charge_en_in || active_en_in) && !charge_done_out && !active_done_out)
    begin
      cnt <= cnt + 1;
      if (cnt >= int'(wait_in))
      begin
        cnt <= 0;
        if (charge_en_in)
          charge_done_out <= 1'b1;
        else
        begin
          active_done_out <= 1'b1;
          voltage_out <= end_voltage_in;
        end
      end
    end
  end
endmodule // ccop_pwr_model
`default_nettype wire

// >>> verif/testbench.sv
// self-checking bench for the capacitor charge optimizer
// assumes the power stage model answers every charge and active phase
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clk, rst_n, ce, wr, pin, cdone, adone, cen, aen, seen;
  logic [7:0] addr, wdata, rdata, rd;
  logic [3:0] volt, tgt, vend, dly, lvl, v;
  logic [3:0] expq[$];
  logic [3:0] pick [0:4];
  int err_count, compares, seed;
  ccop_top uut (.CLK_IN(clk), .RESET_N_IN(rst_n), .CE_IN(ce),
    .REG_WR_IN(wr), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
    .REG_RDATA_OUT(rdata), .START_PIN_IN(pin), .CHARGE_DONE_IN(cdone),
    .ACTIVE_DONE_IN(adone), .STORAGE_CAPACITOR_VOLTAGE_IN(volt),
    .CHARGE_EN_OUT(cen), .ACTIVE_EN_OUT(aen), .CHARGE_TARGET_OUT(tgt));
  ccop_pwr_model pwr (.clk_in(clk), .charge_en_in(cen),
    .active_en_in(aen), .end_voltage_in(vend), .wait_in(dly),
    .charge_done_out(cdone), .active_done_out(adone), .voltage_out(volt));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic end_of_test;
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a);
    @(negedge clk);
    addr = a;
    @(negedge clk);
    rd = rdata;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    rreg(a);
    check(rd, e);
  endtask
  task automatic wait_idle;
    rd = 8'h00;
    for (int k = 0; k < 200 && rd[2:0] !== 3'h1; k++)
      rreg(8'h08);
    check({5'h0, rd[2:0]}, 8'h01);
  endtask
  function automatic logic [3:0] nxt(input logic [3:0] l, input logic [3:0] c);
    if (c > 4'h3)
      return (l == 4'h0) ? l : l - 4'h1;
    if (c >= 4'h2)
      return (l == 4'hf) ? l : l + 4'h1;
    return (l >= 4'he) ? 4'hf : l + 4'h2;
  endfunction
  // one on-demand cycle, started by register or by pin
  task automatic run_cycle(input logic [3:0] c, input logic [3:0] e,
    input logic use_pin);
    expq.push_back(e);
    vend = c;
    dly = 4'($random(seed)) & 4'h3;
    if (use_pin)
    begin
      @(negedge clk);
      pin = 1'b1;
    end
    else
      wreg(8'h08, 8'h01);
    for (int k = 0; k < 20 && !cen; k++)
      @(negedge clk);
    wait_idle();
    pin = 1'b0;
  endtask
  always @(negedge clk)
  begin
    if (cen && !seen)
    begin
      if (expq.size() == 0)
        check(8'hff, 8'h00);
      else
        check({4'h0, tgt}, {4'h0, expq.pop_front()});
    end
    // done levels read here are those the design saw at the last rise
    if (cdone)
      check({6'h00, cen, aen}, 8'h01);
    if (adone)
      check({6'h00, cen, aen}, 8'h00);
    seen = cen;
  end
  initial
  begin
    #400000;
    err_count++;
    end_of_test();
  end
  initial
  begin
    seed = 32'h0cab;
    err_count = 0;
    compares = 0;
    {ce, wr, pin, addr, wdata, vend, dly, rst_n} = '0;
    pick = '{4'h9, 4'h9, 4'h0, 4'h3, 4'h9};
    ce = 1'b1;
    repeat (10) @(negedge clk);
    check({cen, aen, 2'h0, tgt}, 8'h00);
    rst_n = 1'b1;
    rreg(8'h08);
    check({5'h0, rd[2:0]}, 8'h00);
    wait_idle();
    rchk(8'h07, 8'h01);
    rchk(8'h13, 8'h03);
    // a write while the enable is low must not land
    ce = 1'b0;
    wreg(8'h13, 8'h01);
    ce = 1'b1;
    rchk(8'h13, 8'h03);
    rchk(8'h12, 8'h18);
    rchk(8'h55, 8'h00);
    rchk(8'h08, 8'hf1);
    lvl = 4'hf;
    for (int i = 0; i < 8; i++)
    begin
      v = (i < 3) ? 4'($random(seed)) : pick[i-3];
      run_cycle(v, lvl, i[0]);
      lvl = nxt(lvl, v);
      rchk(8'h08, {lvl, 4'h1});
    end
    wreg(8'h08, 8'h08);
    rchk(8'h08, 8'hf1);
    wreg(8'h07, 8'h00);
    wreg(8'h12, 8'h15);
    run_cycle(4'h9, 4'h5, 1'b0);
    wreg(8'h12, 8'h05);
    wreg(8'h07, 8'h02);
    wreg(8'h08, 8'h08);
    rchk(8'h08, 8'he1);
    wreg(8'h07, 8'h01);
    rchk(8'h08, 8'hf1);
    end_of_test();
  end
endmodule // testbench
`default_nettype wire
